/* design/pgagg_pkg.sv */
/*
  Package of the power-good aggregator: register map, field layout, reset
  values, blanking timing and the state and carrier types.
  Assumes a single 25 MHz logic clock and 8-bit register data.
*/
package pgagg_pkg;

  // ------------------------------------------------------------------
  // Register map and widths
  // ------------------------------------------------------------------
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 8;
  localparam int unsigned NRAIL = 4;  // Buck0, buck1, linear0, linear1
  localparam logic [AW-1:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [AW-1:0] ADDR_CTRL_TWO = 8'h01;
  localparam logic [AW-1:0] ADDR_FAULT    = 8'h02;
  localparam logic [AW-1:0] ADDR_FLAGS    = 8'h03;
  localparam logic [AW-1:0] ADDR_MASK     = 8'h04;
  localparam logic [AW-1:0] ADDR_STATUS   = 8'h05;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int unsigned BIT_TWARN_SEL  = 0;
  localparam int unsigned BIT_CONT_MODE  = 1;
  localparam int unsigned BIT_FAULT_GATE = 2;
  localparam int unsigned BIT_POLARITY   = 3;
  localparam int unsigned BIT_OPEN_DRAIN = 4;
  localparam int unsigned BIT_OVP_FLAG   = 0;
  localparam int unsigned BIT_TSD_FLAG   = 1;
  localparam int unsigned BIT_LOSS_FLAG  = 2;
  localparam int unsigned BIT_LOSS_MASK  = 0;
  localparam int unsigned BIT_ST_GOOD    = 0;
  localparam int unsigned BIT_ST_BLANK   = 1;
  localparam int unsigned BIT_ST_MODE    = 2;
  localparam int unsigned BIT_ST_RAIL    = 4;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [DW-1:0] RST_CTRL_ONE = 8'h00;
  localparam logic [DW-1:0] RST_CTRL_TWO = 8'h08;  // Active-high push-pull pin
  localparam logic          RST_MASK     = 1'b0;

  // ------------------------------------------------------------------
  // Blanking timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_RATE_KHZ      = 25000;
  localparam int unsigned BLANK_TIME_US     = 800;
  localparam int unsigned BLANK_CYCLES_DFLT = (BLANK_TIME_US * CLK_RATE_KHZ) / 1000;
  localparam int unsigned BLANK_CNT_W       = 16;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [0:0] {PH_LOAD, PH_RUN} pgagg_phase_type;

  typedef struct packed {
    logic [NRAIL-1:0] enable;   // Regulator enabled
    logic [NRAIL-1:0] under;    // Undervoltage comparator, 1 = low
    logic [NRAIL-1:0] over;     // Overvoltage comparator, 1 = high
    logic [NRAIL-1:0] ramping;  // Moving between two targets
  } pgagg_rail_type;

  typedef struct packed {
    pgagg_phase_type        phase;
    logic [DW-1:0]          ctrl_one;  // [3:0] select, [7:4] window
    logic [DW-1:0]          ctrl_two;
    logic [NRAIL-1:0]       fault;
    logic                   ovp_flag;
    logic                   tsd_flag;
    logic                   loss_flag;
    logic                   loss_mask;
    logic                   good;
    logic [BLANK_CNT_W-1:0] blank_cnt;
    logic [NRAIL-1:0]       en_prev;
    logic                   pin_out;
    logic                   pin_oe;
    logic                   alert;
    logic [DW-1:0]          rdata;
  } pgagg_state_type;

  localparam pgagg_state_type ST_RESET = '{
    phase:     PH_LOAD,
    ctrl_one:  RST_CTRL_ONE,
    ctrl_two:  RST_CTRL_TWO,
    fault:     4'h0,
    ovp_flag:  1'b0,
    tsd_flag:  1'b0,
    loss_flag: 1'b0,
    loss_mask: RST_MASK,
    good:      1'b1,
    blank_cnt: 16'h0000,
    en_prev:   4'h0,
    pin_out:   1'b1,
    pin_oe:    1'b1,
    alert:     1'b0,
    rdata:     8'h00
  };

endpackage

/* design/pgagg_top.sv */
/*
  Power-good aggregator: combines rail monitors, thermal warning and the
  overvoltage and thermal-shutdown flags into one power-good pin.
  Assumes all inputs are synchronous to clk_sys and the register master
  follows the one-cycle strobe protocol with read data one cycle later.
*/
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps

module pgagg_top
  import pgagg_pkg::*;
#(
  parameter int unsigned BLANK_CYCLES = BLANK_CYCLES_DFLT
) (
  input  wire logic           clk_sys,
  input  wire logic           resetn,
  input  wire logic [AW-1:0]  reg_addr,
  input  wire logic [DW-1:0]  reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic      [DW-1:0]  reg_rdata,
  input  wire pgagg_rail_type rails,
  input  wire logic           thermal_warning_status,
  input  wire logic           input_overvoltage_detect,
  input  wire logic           thermal_shutdown_detect,
  input  wire logic           seq_step_req,
  input  wire logic           voltage_change_req,
  input  wire logic           otp_load_done,
  input  wire logic           otp_continuous_mode,
  output logic                power_good_out,
  output logic                power_good_oe,
  output logic                good_loss_alert
);

  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic       rst_n;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [NRAIL-1:0] rail_valid(input pgagg_rail_type r,
                                                  input logic [NRAIL-1:0] window);
    rail_valid = ~r.under & (~window | ~r.over);
  endfunction

  function automatic logic pin_level(input logic good, input logic pol);
    pin_level = pol ? good : ~good;
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  pgagg_state_type st_ff;
  pgagg_state_type nxt_st;

  logic [NRAIL-1:0] sel;
  logic [NRAIL-1:0] window;
  logic [NRAIL-1:0] valid;
  logic [NRAIL-1:0] monitored;
  logic [NRAIL-1:0] en_rise;
  logic             cont;
  logic             blanking;
  logic             restart;
  logic             src_ok;
  logic             fault_watch;
  logic             wr_fault;
  logic             wr_flags;

  assign sel       = st_ff.ctrl_one[NRAIL-1:0];
  assign window    = st_ff.ctrl_one[DW-1:NRAIL];
  assign valid     = rail_valid(rails, window);
  assign monitored = sel & rails.enable;
  assign en_rise   = rails.enable & ~st_ff.en_prev;
  assign cont      = st_ff.ctrl_two[BIT_CONT_MODE];
  assign blanking  = (st_ff.blank_cnt != '0);
  assign restart   = seq_step_req | voltage_change_req | (|en_rise);
  assign wr_fault  = reg_wr && (reg_addr == ADDR_FAULT);
  assign wr_flags  = reg_wr && (reg_addr == ADDR_FLAGS);

  // All sources valid
  assign src_ok = (&(~monitored | valid))
                & ~(st_ff.ctrl_two[BIT_TWARN_SEL] & thermal_warning_status)
                & ~st_ff.ovp_flag & ~st_ff.tsd_flag;

  // Gated mode records faults only outside blanking and its restart cycle; ramping rails are not faults
  assign fault_watch = (st_ff.phase == PH_RUN) && (cont ? 1'b1 : (!blanking && !restart));

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.en_prev = rails.enable;
    nxt_st.rdata   = '0;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL_ONE: begin
          nxt_st.ctrl_one = reg_wdata;
        end
        ADDR_CTRL_TWO: begin
          nxt_st.ctrl_two = reg_wdata;
        end
        ADDR_MASK: begin
          nxt_st.loss_mask = reg_wdata[BIT_LOSS_MASK];
        end
        default: begin
        end
      endcase
    end

    // Write-one-to-clear, set wins over clear
    nxt_st.fault = (st_ff.fault & ~(wr_fault ? reg_wdata[NRAIL-1:0] : '0))
                 | (fault_watch ? (monitored & ~valid & ~rails.ramping) : '0);
    nxt_st.ovp_flag = (st_ff.ovp_flag & ~(wr_flags & reg_wdata[BIT_OVP_FLAG]))
                    | input_overvoltage_detect;
    nxt_st.tsd_flag = (st_ff.tsd_flag & ~(wr_flags & reg_wdata[BIT_TSD_FLAG]))
                    | thermal_shutdown_detect;

    // Blanking counter
    if (restart) begin
      nxt_st.blank_cnt = BLANK_CNT_W'(BLANK_CYCLES);
    end else if (blanking) begin
      nxt_st.blank_cnt = st_ff.blank_cnt - 1'b1;
    end

    case (st_ff.phase)
      PH_LOAD: begin
        nxt_st.good = 1'b1;
        if (otp_load_done) begin
          nxt_st.phase = PH_RUN;
          nxt_st.ctrl_two[BIT_CONT_MODE] = otp_continuous_mode;
          nxt_st.good = 1'b1;
        end
      end
      PH_RUN: begin
        if (cont) begin
          // Follows live status; ramp and fresh enable force inactive
          nxt_st.good = src_ok
                      & ~(|(monitored & rails.ramping))
                      & ~(|(sel & en_rise))
                      & ~(st_ff.ctrl_two[BIT_FAULT_GATE] & (|st_ff.fault));
        end else if (blanking || restart) begin
          nxt_st.good = st_ff.good;
        end else if ((|st_ff.fault) || st_ff.ovp_flag || st_ff.tsd_flag) begin
          nxt_st.good = 1'b0;
        end else begin
          nxt_st.good = src_ok & ~(st_ff.ctrl_two[BIT_FAULT_GATE] & (|st_ff.fault));
        end
      end
      default: begin
        nxt_st.phase = PH_LOAD;
      end
    endcase

    // Loss flag; set wins over clear
    nxt_st.loss_flag = (st_ff.loss_flag & ~(wr_flags & reg_wdata[BIT_LOSS_FLAG]))
                     | (st_ff.good & ~nxt_st.good);
    nxt_st.alert = nxt_st.loss_flag & ~nxt_st.loss_mask;

    // Open drain only ever pulls low
    nxt_st.pin_out = nxt_st.ctrl_two[BIT_OPEN_DRAIN] ? 1'b0
                   : pin_level(nxt_st.good, nxt_st.ctrl_two[BIT_POLARITY]);
    nxt_st.pin_oe  = nxt_st.ctrl_two[BIT_OPEN_DRAIN]
                   ? ~pin_level(nxt_st.good, nxt_st.ctrl_two[BIT_POLARITY]) : 1'b1;

    // Register reads, answered next cycle
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL_ONE: nxt_st.rdata = st_ff.ctrl_one;
        ADDR_CTRL_TWO: nxt_st.rdata = st_ff.ctrl_two;
        ADDR_FAULT:    nxt_st.rdata = {{(DW-NRAIL){1'b0}}, st_ff.fault};
        ADDR_FLAGS: begin
          nxt_st.rdata[BIT_OVP_FLAG]  = st_ff.ovp_flag;
          nxt_st.rdata[BIT_TSD_FLAG]  = st_ff.tsd_flag;
          nxt_st.rdata[BIT_LOSS_FLAG] = st_ff.loss_flag;
        end
        ADDR_MASK:     nxt_st.rdata[BIT_LOSS_MASK] = st_ff.loss_mask;
        ADDR_STATUS: begin
          nxt_st.rdata[BIT_ST_GOOD]  = st_ff.good;
          nxt_st.rdata[BIT_ST_BLANK] = blanking;
          nxt_st.rdata[BIT_ST_MODE]  = cont;
          nxt_st.rdata[DW-1:BIT_ST_RAIL] = valid;
        end
        default: nxt_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata       = st_ff.rdata;
  assign power_good_out  = st_ff.pin_out;
  assign power_good_oe   = st_ff.pin_oe;
  assign good_loss_alert = st_ff.alert;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_DISABLED_MASKED: assert property (!rails.enable[1] && !st_ff.fault[1] |=> !st_ff.fault[1])
    else $error("disabled rail latched a fault");
  AST_SOURCES_BAD: assert property (st_ff.phase == PH_RUN && cont && !src_ok |=> !st_ff.good)
    else $error("power-good active with a bad source");
  AST_WINDOW_OVER: assert property (fault_watch && monitored[0] && window[0] && rails.over[0]
                                    && !rails.ramping[0] |=> st_ff.fault[0])
    else $error("overvoltage not latched in window mode");
  AST_PIN_POLARITY: assert property (!nxt_st.ctrl_two[BIT_OPEN_DRAIN]
                                     |=> power_good_out == (st_ff.ctrl_two[BIT_POLARITY] ~^ st_ff.good))
    else $error("pin level does not match polarity");
  AST_LOAD_ACTIVE: assert property (st_ff.phase == PH_LOAD && otp_load_done
                                    |=> st_ff.good && cont == $past(otp_continuous_mode))
    else $error("load exit not active or mode not loaded");
  AST_BLANK_HOLD: assert property (st_ff.phase == PH_RUN && !cont && blanking
                                   && !$past(cont) |=> $stable(st_ff.good))
    else $error("power-good moved during blanking");
  AST_GATED_SUSPEND: assert property (st_ff.phase == PH_RUN && !cont && !blanking && !restart
                                      && (|st_ff.fault) |=> !st_ff.good)
    else $error("gated mode resumed with fault pending");
  AST_FAULT_KEPT: assert property (st_ff.fault[0] && !(wr_fault && reg_wdata[0]) |=> st_ff.fault[0])
    else $error("fault bit lost without clear");
  AST_ENABLE_DROP: assert property (st_ff.phase == PH_RUN && cont && (|(sel & en_rise)) |=> !st_ff.good)
    else $error("enable did not drop power-good");
  AST_RAMP_LOW: assert property (st_ff.phase == PH_RUN && cont && (|(monitored & rails.ramping))
                                 [*2] |=> !st_ff.good)
    else $error("power-good active while ramping");
  AST_FAULT_GATE: assert property (st_ff.phase == PH_RUN && cont && st_ff.ctrl_two[BIT_FAULT_GATE]
                                   && (|st_ff.fault) |=> !st_ff.good)
    else $error("pending fault did not gate power-good");
  AST_LOSS_FLAG: assert property ($fell(st_ff.good) |-> st_ff.loss_flag)
    else $error("loss flag not set on falling power-good");
  AST_BLANK_RESTART: assert property (restart |=> st_ff.blank_cnt == BLANK_CNT_W'(BLANK_CYCLES))
    else $error("blanking counter not restarted");

  COV_GATED_LOSS: cover property (st_ff.phase == PH_RUN && !cont ##1 $fell(st_ff.good));
  COV_CONT_RECOVER: cover property (cont && $fell(st_ff.good) ##[1:50] $rose(st_ff.good) && (|st_ff.fault));
  COV_FAULT_CLEAR: cover property ($fell(|st_ff.fault));
  COV_OPEN_DRAIN: cover property (st_ff.ctrl_two[BIT_OPEN_DRAIN] && !power_good_oe);

endmodule // pgagg_top

/* testbench/pgagg_good_sink.sv */
/*
  Model of the line fed by the power-good pin: a processor reset input
  or an enable line that others may wire-OR onto.
  Assumes a pull-up on the line, so a released pin reads high.
*/
`timescale 1ns/100ps

module pgagg_good_sink (
  input  wire logic power_good_out,
  input  wire logic power_good_oe,
  output logic      wire_level
);
  // Released open-drain pin floats up to the pull-up level
  assign wire_level = power_good_oe ? power_good_out : 1'b1;
endmodule // pgagg_good_sink

/* testbench/power_good_aggregator_bench.sv */
/*
  Self-checking bench of the power-good aggregator: drives rail monitors,
  flags and the register port, and judges the status, pin and alert.
  Assumes the design's blanking shortened to 20 cycles and a pulled-up line.
*/
`timescale 1ns/100ps

module power_good_aggregator_bench
  import pgagg_pkg::*;
;
  logic           clk_sys, resetn, reg_wr, reg_rd, twarn, ovp_det, tsd_det;
  logic           step_req, chg_req, load_done, otp_cont, pg_out, pg_oe, alert, wire_level;
  logic [AW-1:0]  reg_addr;
  logic [DW-1:0]  reg_wdata, reg_rdata;
  pgagg_rail_type rails;
  int             miscompares, samples_checked, cycles;

  pgagg_top #(.BLANK_CYCLES(20)) i_pgagg_top (
    .clk_sys                  (clk_sys),
    .resetn                   (resetn),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_wr                   (reg_wr),
    .reg_rd                   (reg_rd),
    .reg_rdata                (reg_rdata),
    .rails                    (rails),
    .thermal_warning_status   (twarn),
    .input_overvoltage_detect (ovp_det),
    .thermal_shutdown_detect  (tsd_det),
    .seq_step_req             (step_req),
    .voltage_change_req       (chg_req),
    .otp_load_done            (load_done),
    .otp_continuous_mode      (otp_cont),
    .power_good_out           (pg_out),
    .power_good_oe            (pg_oe),
    .good_loss_alert          (alert)
  );

  pgagg_good_sink i_pgagg_good_sink (
    .power_good_out (pg_out),
    .power_good_oe  (pg_oe),
    .wire_level     (wire_level)
  );

  // ------------------------------------------------------------------
  // Clock, watchdog and verdict
  // ------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Bus and compare helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Trailing idle cycle keeps two strobes from landing in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, exp);
    @(posedge clk_sys);
  endtask

  task automatic gd(input logic exp);
    repeat (3) @(posedge clk_sys);
    rdc(8'h05, 8'h01, {7'h0, exp});
    chk({7'h0, wire_level}, {7'h0, exp});
  endtask

  task automatic clr();
    repeat (2) @(posedge clk_sys);
    wr(8'h02, 8'h0f);
    wr(8'h03, 8'h07);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    rdc(8'h00, 8'hff, 8'h00);
    rdc(8'h01, 8'hff, 8'h08);
    rdc(8'h07, 8'hff, 8'h00);
    chk({6'h0, pg_oe, pg_out}, 8'h03);
    otp_cont  <= 1'b1;
    load_done <= 1'b1;
    @(posedge clk_sys);
    load_done <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rdc(8'h05, 8'h05, 8'h05);
  endtask

  task automatic t_enable();
    wr(8'h00, 8'h01);
    rails.enable[0] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdc(8'h03, 8'h04, 8'h04);
    chk({7'h0, alert}, 8'h01);
    wr(8'h03, 8'h04);
    chk({7'h0, alert}, 8'h00);
    wr(8'h04, 8'h01);
    rails.under[0] <= 1'b1;
    gd(1'b0);
    chk({7'h0, alert}, 8'h00);
    rails.under[0] <= 1'b0;
    gd(1'b1);
    rdc(8'h02, 8'hff, 8'h01);
    wr(8'h02, 8'h0e);
    rdc(8'h02, 8'hff, 8'h01);
    wr(8'h02, 8'h01);
    rdc(8'h02, 8'hff, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h01, 8'h0e);
    rails.under[0] <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rails.under[0] <= 1'b0;
    gd(1'b0);
    wr(8'h02, 8'h01);
    gd(1'b1);
    wr(8'h01, 8'h0a);
    clr();
  endtask

  task automatic t_sources();
    rails.over[0] <= 1'b1;
    gd(1'b1);
    wr(8'h00, 8'h11);
    gd(1'b0);
    rails.over[0]   <= 1'b0;
    rails.enable[2] <= 1'b1;
    rails.under[2]  <= 1'b1;
    gd(1'b1);
    rails.under[1] <= 1'b1;
    wr(8'h00, 8'h13);
    gd(1'b1);
    twarn <= 1'b1;
    gd(1'b1);
    wr(8'h01, 8'h0b);
    gd(1'b0);
    twarn            <= 1'b0;
    rails.ramping[0] <= 1'b1;
    gd(1'b0);
    rails.ramping[0] <= 1'b0;
    gd(1'b1);
    wr(8'h01, 8'h0a);
    clr();
  endtask

  task automatic t_flags();
    for (int i = 0; i < 2; i++) begin
      {tsd_det, ovp_det} <= 2'b01 << i;
      @(posedge clk_sys);
      {tsd_det, ovp_det} <= 2'b00;
      gd(1'b0);
      rdc(8'h03, 8'h03, 8'h01 << i);
      wr(8'h03, 8'h01 << i);
      gd(1'b1);
    end
    clr();
  endtask

  task automatic t_pin();
    wr(8'h01, 8'h02);
    repeat (3) @(posedge clk_sys);
    rdc(8'h05, 8'h01, 8'h01);
    chk({6'h0, pg_oe, pg_out}, 8'h02);
    wr(8'h01, 8'h1a);
    repeat (3) @(posedge clk_sys);
    chk({6'h0, pg_oe, wire_level}, 8'h01);
    rails.under[0] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({6'h0, pg_oe, wire_level}, 8'h02);
    rails.under[0] <= 1'b0;
    wr(8'h01, 8'h0a);
    clr();
  endtask

  task automatic t_gated();
    wr(8'h01, 8'h08);
    step_req       <= 1'b1;
    rails.under[0] <= 1'b1;
    @(posedge clk_sys);
    step_req <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rdc(8'h05, 8'h07, 8'h03);
    chg_req <= 1'b1;
    @(posedge clk_sys);
    chg_req <= 1'b0;
    repeat (14) @(posedge clk_sys);
    rdc(8'h05, 8'h03, 8'h03);
    repeat (10) @(posedge clk_sys);
    rdc(8'h05, 8'h03, 8'h00);
    rails.under[0] <= 1'b0;
    gd(1'b0);
    wr(8'h02, 8'h01);
    gd(1'b1);
  endtask

  initial begin
    {resetn, reg_wr, reg_rd, twarn, ovp_det, tsd_det, step_req, chg_req, load_done, otp_cont} = '0;
    reg_addr        = '0;
    reg_wdata       = '0;
    rails           = '0;
    miscompares     = 0;
    samples_checked = 0;
    cycles          = 0;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_enable();
    t_sources();
    t_flags();
    t_pin();
    t_gated();
    wrap_up();
  end
endmodule // power_good_aggregator_bench
